// ===== include/rh_hub_defs.svh
// register map, field positions and reset values of the hub register pair
// assumes: included by its bare name from package and design files
`ifndef RH_HUB_DEFS_SVH
`define RH_HUB_DEFS_SVH
`define CMD_DESCB_RD 8'h13
`define CMD_DESCB_WR 8'h93
`define CMD_HSTAT_RD 8'h14
`define CMD_HSTAT_WR 8'h94
`define DESCB_MASK_LSB 16
`define DESCB_MASK_MSB 18
`define DESCB_REM_LSB 0
`define DESCB_REM_MSB 2
`define HS_POWER_OFF_BIT 0
`define HS_OVC_BIT 1
`define HS_WAKE_BIT 15
`define HS_POWER_ON_BIT 16
`define HS_OVC_CHG_BIT 17
`define HS_WAKE_CLR_BIT 31
`define RST_PORT_MASK 3'h0
`define RST_REMOVABLE 3'h0
`define RST_PORT_POWER 2'h0
`define USED_PORT_BITS 3'h6
`endif

// ===== include/rh_hub_pkg.sv
// types shared by the hub register bank and its bus port
// assumes: nothing beyond the constants header
`include "rh_hub_defs.svh"
package rh_hub_pkg;
  typedef logic [7:0] cmd_t;
  typedef logic [31:0] word_t;
  typedef logic [2:0] port_bits_t;
endpackage

// ===== include/rh_cmd_if.sv
// decoded host bus command passed from the bus port to the register bank
// assumes: one clock, mclk, shared by both ends
`timescale 1ns/10ps
interface rh_cmd_if;
  import rh_hub_pkg::*;
  logic wr_descb;
  logic wr_hstat;
  logic sel_descb;
  logic sel_hstat;
  word_t wdata;
  modport port (output wr_descb, wr_hstat, sel_descb, sel_hstat, wdata);
  modport bank (input wr_descb, wr_hstat, sel_descb, sel_hstat, wdata);
endinterface

// ===== src/rh_cmd_decode.sv
// command decoder: turns command code strobes into register selects
// assumes: cmd_valid is a one-cycle pulse synchronous to mclk
`timescale 1ns/10ps
`include "rh_hub_defs.svh"
module rh_cmd_decode (
  input wire logic cmd_valid,
  input wire rh_hub_pkg::cmd_t cmd_code,
  input wire rh_hub_pkg::word_t cmd_wdata,
  rh_cmd_if.port dec
);
  import rh_hub_pkg::*;
  // pure decode, registered downstream
  always_comb begin
    dec.wr_descb = cmd_valid && (cmd_code == `CMD_DESCB_WR);
    dec.wr_hstat = cmd_valid && (cmd_code == `CMD_HSTAT_WR);
    dec.sel_descb = cmd_valid && (cmd_code == `CMD_DESCB_RD);
    dec.sel_hstat = cmd_valid && (cmd_code == `CMD_HSTAT_RD);
    dec.wdata = cmd_wdata;
  end
endmodule

// ===== src/root_hub_power_status_regs.sv
// root hub descriptor b and hub status registers with global power control
// assumes: host bus commands arrive as one-cycle strobes on mclk
// Operation
// - descriptor b is read with code 13h and written with code 93h.
// - a set mask bit gives that port to per-port commands only.
// - in global switching mode the mask is ignored and global commands rule.
// - mask bit 0 is reserved, bit 1 is port 1, bit 2 is port 2.
// - removable flags bits 2:0, clear means removable, set means fixed.
// - removable bit 0 is reserved, bit 1 is port 1, bit 2 is port 2.
// - hub status is read with code 14h and written with code 94h.
// - hub status low half holds status, high half holds change bits.
// - overcurrent change bit 17 sets on any indicator change, w1c.
// - writing 1 to bit 16 powers ports on, and bit 16 reads 0.
// - bit 15 write 1 sets wakeup enable, bit 31 write 1 clears it.
// - writing 1 to bit 0 powers ports off, and bit 0 reads 0.
`timescale 1ns/10ps
`include "rh_hub_defs.svh"
module root_hub_power_status_regs (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // host command bus
  input wire logic cmd_valid,
  input wire rh_hub_pkg::cmd_t cmd_code,
  input wire rh_hub_pkg::word_t cmd_wdata,
  output logic rd_valid,
  output rh_hub_pkg::word_t rd_data,
  // root hub surroundings
  input wire logic power_switch_select,
  input wire logic overcurrent_in,
  // per-port power status, bit n is port n
  output rh_hub_pkg::port_bits_t port_power,
  output logic wakeup_enable
);
  import rh_hub_pkg::*;

  typedef struct packed {
    port_bits_t port_power_mask;
    port_bits_t removable_flags;
    logic overcurrent_flag;
    logic overcurrent_change_flag;
    logic wakeup_enable_flag;
    port_bits_t power;
    logic rd_valid;
    word_t rd_data;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  rh_cmd_if cmd ();
  word_t descb_view;
  word_t hstat_view;
  port_bits_t global_ports;

  rh_cmd_decode u_dec (
    .cmd_valid(cmd_valid),
    .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata),
    .dec(cmd)
  );

  // read views; reserved and command-only bits stay zero
  always_comb begin
    descb_view = 32'h0;
    descb_view[`DESCB_MASK_MSB:`DESCB_MASK_LSB] = st_r.port_power_mask;
    descb_view[`DESCB_REM_MSB:`DESCB_REM_LSB] = st_r.removable_flags;
    hstat_view = 32'h0;
    // bits 0 and 16 have no local power status and read zero
    hstat_view[`HS_OVC_BIT] = st_r.overcurrent_flag;
    hstat_view[`HS_WAKE_BIT] = st_r.wakeup_enable_flag;
    hstat_view[`HS_OVC_CHG_BIT] = st_r.overcurrent_change_flag;
  end

  // ports that follow global commands: all in global mode, else unmasked
  always_comb begin
    if (!power_switch_select) begin
      global_ports = `USED_PORT_BITS;
    end else begin
      global_ports = ~st_r.port_power_mask & `USED_PORT_BITS;
    end
  end

  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.rd_valid = cmd.sel_descb | cmd.sel_hstat;
    if (cmd.sel_descb) begin
      st_nxt.rd_data = descb_view;
    end else if (cmd.sel_hstat) begin
      st_nxt.rd_data = hstat_view;
    end
    if (cmd.wr_descb) begin
      // bit 0 of each field is reserved and kept zero
      st_nxt.port_power_mask =
        cmd.wdata[`DESCB_MASK_MSB:`DESCB_MASK_LSB] & `USED_PORT_BITS;
      st_nxt.removable_flags =
        cmd.wdata[`DESCB_REM_MSB:`DESCB_REM_LSB] & `USED_PORT_BITS;
    end
    st_nxt.overcurrent_flag = overcurrent_in;
    if (cmd.wr_hstat) begin
      if (cmd.wdata[`HS_OVC_CHG_BIT]) begin
        st_nxt.overcurrent_change_flag = 1'b0;
      end
      if (cmd.wdata[`HS_WAKE_BIT]) begin
        st_nxt.wakeup_enable_flag = 1'b1;
      end else if (cmd.wdata[`HS_WAKE_CLR_BIT]) begin
        st_nxt.wakeup_enable_flag = 1'b0;
      end
      // off wins if both are written at once, the safer outcome
      if (cmd.wdata[`HS_POWER_OFF_BIT]) begin
        st_nxt.power = st_r.power & ~global_ports;
      end else if (cmd.wdata[`HS_POWER_ON_BIT]) begin
        st_nxt.power = st_r.power | global_ports;
      end
    end
    // hardware set beats the software clear in the same cycle
    if (overcurrent_in != st_r.overcurrent_flag) begin
      st_nxt.overcurrent_change_flag = 1'b1;
    end
  end

  // state register; reset values are arbitrary, software reprograms them
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.port_power_mask <= `RST_PORT_MASK;
      st_r.removable_flags <= `RST_REMOVABLE;
      st_r.power <= {1'b0, `RST_PORT_POWER};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_valid = st_r.rd_valid;
  assign rd_data = st_r.rd_data;
  assign port_power = st_r.power;
  assign wakeup_enable = st_r.wakeup_enable_flag;

  // assertions on the flag, power and read paths
  AST_OVC_CHG_SET: assert property (
    @(posedge mclk) disable iff (!rst_n)
    overcurrent_in != st_r.overcurrent_flag |=> st_r.overcurrent_change_flag
  ) else $error("overcurrent change not flagged");
  AST_GLOBAL_OFF: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cmd.wr_hstat && cmd.wdata[0] && !power_switch_select
    |=> port_power == 3'h0
  ) else $error("global off failed");
  AST_GLOBAL_ON: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cmd.wr_hstat && cmd.wdata[16] && !cmd.wdata[0] && !power_switch_select
    |=> port_power == 3'h6
  ) else $error("global on failed");
  AST_MASKED_KEEP: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cmd.wr_hstat && power_switch_select && st_r.port_power_mask[1]
    |=> port_power[1] == $past(st_r.power[1])
  ) else $error("masked port changed");
  AST_WAKE_SET: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cmd.wr_hstat && cmd.wdata[15] |=> wakeup_enable
  ) else $error("wakeup set failed");
  AST_HSTAT_READ: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cmd_valid && cmd_code == 8'h14 |=> rd_valid && rd_data[16] == 1'b0
    && rd_data[0] == 1'b0 && rd_data[14:2] == 13'h0
  ) else $error("hub status read bad");
  AST_DESCB_RSV: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cmd_valid && cmd_code == 8'h13 |=> rd_valid && rd_data[0] == 1'b0
    && rd_data[16] == 1'b0 && rd_data[15:3] == 13'h0
  ) else $error("descriptor reserved bit set");
  AST_DESCB_WRITE: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cmd.wr_descb ##1 (cmd_valid && cmd_code == 8'h13) |=>
    rd_data[2:1] == $past(cmd_wdata[2:1], 2)
  ) else $error("removable flags lost");
  AST_OVC_CHG_CLR: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cmd.wr_hstat && cmd.wdata[17] && overcurrent_in == st_r.overcurrent_flag
    |=> !st_r.overcurrent_change_flag
  ) else $error("overcurrent change not cleared");
  AST_OVC_FOLLOW: assert property (
    @(posedge mclk) disable iff (!rst_n)
    1'b1 |=> st_r.overcurrent_flag == $past(overcurrent_in)
  ) else $error("overcurrent status lags");
  AST_WAKE_CLR: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cmd.wr_hstat && cmd.wdata[31] && !cmd.wdata[15] |=> !wakeup_enable
  ) else $error("wakeup clear failed");
  AST_WAKE_KEEP: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !cmd.wr_hstat |=> $stable(wakeup_enable)
  ) else $error("wakeup changed without a write");
  AST_PORT_RSV: assert property (
    @(posedge mclk) disable iff (!rst_n)
    port_power[0] == 1'b0 && st_r.port_power_mask[0] == 1'b0
    && st_r.removable_flags[0] == 1'b0
  ) else $error("reserved port bit set");
  AST_PERPORT_ON: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cmd.wr_hstat && cmd.wdata[16] && !cmd.wdata[0] && power_switch_select
    && !st_r.port_power_mask[2] |=> port_power[2]
  ) else $error("unmasked port not powered on");
  AST_PERPORT_OFF: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cmd.wr_hstat && cmd.wdata[0] && power_switch_select
    && !st_r.port_power_mask[2] |=> !port_power[2]
  ) else $error("unmasked port not powered off");
  AST_MASK_IGNORED: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cmd.wr_hstat && cmd.wdata[16] && !cmd.wdata[0] && !power_switch_select
    && st_r.port_power_mask[1] |=> port_power[1]
  ) else $error("mask obeyed in global mode");
  AST_POWER_KEEP: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !cmd.wr_hstat |=> $stable(port_power)
  ) else $error("port power changed without a command");
  AST_DESCB_KEEP: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !cmd.wr_descb |=> $stable(st_r.port_power_mask)
    && $stable(st_r.removable_flags)
  ) else $error("descriptor changed without a write");
  AST_MASK_WRITE: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cmd.wr_descb |=> st_r.port_power_mask == ($past(cmd.wdata[18:16]) & 3'h6)
  ) else $error("power mask not written");
  AST_HSTAT_RSV_HI: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cmd.sel_hstat |=> rd_data[31:18] == 14'h0
  ) else $error("hub status upper reserved bits set");
  AST_DESCB_RSV_HI: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cmd.sel_descb |=> rd_data[31:19] == 13'h0
  ) else $error("descriptor upper reserved bits set");
  AST_RD_IDLE: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !cmd.sel_descb && !cmd.sel_hstat |=> !rd_valid && $stable(rd_data)
  ) else $error("read answer without a read");
endmodule

// ===== test/root_hub_power_status_regs_bench.sv
// self-checking bench for the hub descriptor b and hub status registers
// assumes: rh_hub_pkg compiled first; design checks its own assertions
`timescale 1ns/10ps
module root_hub_power_status_regs_bench;
  import rh_hub_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic power_switch_select = 1'b0;
  logic overcurrent_in = 1'b0;
  cmd_t cmd_code = 8'h00;
  word_t cmd_wdata = 32'h0;
  logic rd_valid;
  word_t rd_data;
  port_bits_t port_power;
  logic wakeup_enable;
  int n_fail = 0;
  int total_checks = 0;
  logic go = 1'b0;
  logic [31:0] seed = 32'h97f3;
  logic [2:0] m_mask = 3'h0, m_rem = 3'h0, m_pp = 3'h0;
  logic m_ovc = 1'b0, m_chg = 1'b0, m_wake = 1'b0;
  logic m_rdv = 1'b0, m_rst = 1'b1;
  word_t held = 32'h0;
  word_t exp_q[$];
  cmd_t codes[8] = '{8'h13, 8'h93, 8'h14, 8'h94, 8'h13, 8'h94, 8'h14, 8'h15};
  // ports that follow global commands in the present mode
  wire [2:0] glob = power_switch_select ? (~m_mask & 3'h6) : 3'h6;
  wire wr_st = cmd_valid && cmd_code == 8'h94;

  root_hub_power_status_regs root_hub_power_status_regs_inst (
    .mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rd_valid(rd_valid), .rd_data(rd_data),
    .power_switch_select(power_switch_select),
    .overcurrent_in(overcurrent_in), .port_power(port_power),
    .wakeup_enable(wakeup_enable));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic check(input word_t got, input word_t exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    forever #20 mclk = ~mclk;
  end

  // reference model; later assignments win, so set beats clear for the flags and power off beats power on
  always @(posedge mclk) begin
    if (!rst_n) begin
      {m_mask, m_rem, m_pp, m_ovc, m_chg, m_wake, m_rdv} <= 13'h0;
      m_rst <= 1'b1;
      exp_q.delete();
    end else begin
      m_rst <= 1'b0;
      // a read of either register is answered one cycle later
      m_rdv <= cmd_valid && (cmd_code == 8'h13 || cmd_code == 8'h14);
      m_ovc <= overcurrent_in;
      if (wr_st && cmd_wdata[17]) m_chg <= 1'b0;
      if (overcurrent_in !== m_ovc) m_chg <= 1'b1;
      if (wr_st && cmd_wdata[31]) m_wake <= 1'b0;
      if (wr_st && cmd_wdata[15]) m_wake <= 1'b1;
      if (wr_st && cmd_wdata[16]) m_pp <= m_pp | glob;
      if (wr_st && cmd_wdata[0]) m_pp <= m_pp & ~glob;
      if (cmd_valid && cmd_code == 8'h93) begin
        m_mask <= cmd_wdata[18:16] & 3'h6;
        m_rem <= cmd_wdata[2:0] & 3'h6;
      end
      if (cmd_valid && cmd_code == 8'h13)
        exp_q.push_back({13'h0, m_mask, 13'h0, m_rem});
      if (cmd_valid && cmd_code == 8'h14)
        exp_q.push_back({14'h0, m_chg, 1'b0, m_wake, 13'h0, m_ovc, 1'b0});
    end
  end

  // outputs settle by the falling edge
  always @(negedge mclk) begin
    if (go) begin
      // read word is zero after reset and then stands until the next read
      if (m_rst) held = 32'h0;
      check({29'h0, port_power}, {29'h0, m_pp});
      check({31'h0, wakeup_enable}, {31'h0, m_wake});
      check({31'h0, rd_valid}, {31'h0, m_rdv});
      if (rd_valid === 1'b1 && exp_q.size() == 0) begin
        check({31'h0, rd_valid}, 32'h0);
      end else if (rd_valid === 1'b1) begin
        held = exp_q.pop_front();
        check(rd_data, held);
      end else begin
        check(rd_data, held);
      end
    end
  end

  // random traffic, back to back, with one reset in mid-run
  initial begin
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    go = 1'b1;
    // software sets up descriptor b before normal traffic
    seed = xs(seed);
    cmd_valid = 1'b1;
    cmd_code = 8'h93;
    cmd_wdata = seed;
    for (int i = 0; i < 800; i++) begin
      @(negedge mclk);
      seed = xs(seed);
      cmd_valid = seed[0] | seed[1];
      cmd_code = codes[seed[4:2]];
      if (seed[9:6] == 4'h0) overcurrent_in = ~overcurrent_in;
      if (seed[14:11] == 4'h0) power_switch_select = ~power_switch_select;
      rst_n = !(i == 400 || i == 401);
      seed = xs(seed);
      // software keeps reserved status bits at zero; descriptor is free
      if (cmd_code == 8'h94) cmd_wdata = seed & 32'h80038001;
      else cmd_wdata = seed;
    end
    @(negedge mclk);
    cmd_valid = 1'b0;
    repeat (3) @(negedge mclk);
    check(exp_q.size(), 32'h0);
    print_verdict();
  end

  // watchdog well past the expected run length
  initial begin
    #(40 * 5000);
    n_fail++;
    print_verdict();
  end
endmodule
